// ==== src/convert_ctrl.sv ====
// converter control: start, sleep start, timing, clamping and result registers
`default_nettype none
module convert_ctrl
   import conv_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // cpu side link
   conv_link_if.dev_mp link,
   // analog front end
   output logic [1:0] ref_select_o,
   output logic [4:0] channel_o,
   output logic differential_o,
   output logic converting_o,
   output logic sample_o,
   input wire logic signed [11:0] analog_value_i
);
   typedef enum logic {ST_IDLE, ST_CONVERT} conv_state_e;

   conv_state_e state_ff, nxt_state;
   logic enable_ff, nxt_enable;
   logic free_run_ff, nxt_free_run;
   logic done_ff, nxt_done;
   logic irq_en_ff, nxt_irq_en;
   logic first_ff, nxt_first;
   logic halted_q_ff, nxt_halted_q;
   logic [7:0] select_ff, nxt_select;
   logic [7:0] cnt_ff, nxt_cnt;
   logic [9:0] code_ff, nxt_code;
   logic [1:0] ref_ff, nxt_ref;
   logic [4:0] chan_ff, nxt_chan;
   logic diff_ff, nxt_diff;
   logic [7:0] rdata_ff, nxt_rdata;
   logic wr_ctrl;
   logic start_now;
   logic finish;
   logic sleep_start;
   logic [7:0] fmt_low;
   logic [7:0] fmt_high;
   logic sel_is_diff;

   // clamp the analog sample into the code range of the mode
   function automatic logic [9:0] clamp_code(input logic signed [11:0] v, input logic diff);
      logic signed [11:0] r;
      r = v;
      if (diff) begin
         if (v > DIFF_CODE_MAX) r = DIFF_CODE_MAX;
         if (v < DIFF_CODE_MIN) r = DIFF_CODE_MIN;
      end else begin
         if (v > SE_CODE_MAX) r = SE_CODE_MAX;
         if (v < SE_CODE_MIN) r = SE_CODE_MIN;
      end
      // bit 9 of a differential code is its sign
      return r[9:0];
   endfunction : clamp_code

   // any code in the differential band, same-channel pairs included
   assign sel_is_diff = (select_ff[4:0] >= MUX_DIFF_FIRST) &&
                        (select_ff[4:0] <= MUX_DIFF_LAST);

   // result presentation follows the live alignment bit
   result_format u_format (
      .code_i(code_ff),
      .left_align_i(select_ff[SEL_ALIGN_BIT]),
      .low_o(fmt_low),
      .high_o(fmt_high)
   );

   // strobes and events
   assign wr_ctrl = link.wr && (link.addr == OFS_CTRL);
   assign finish = (state_ff == ST_CONVERT) && (cnt_ff == 8'h01) && enable_ff;
   // halt edge in a noise-friendly mode starts a conversion by itself
   assign sleep_start = link.cpu_halted && !halted_q_ff && enable_ff &&
                        (state_ff == ST_IDLE) &&
                        ((link.sleep_mode == SLEEP_IDLE) ||
                         (link.sleep_mode == SLEEP_NOISE_REDUCE));
   // deeper sleep modes simply do not touch the enable bit
   assign start_now = (wr_ctrl && link.wdata[CTRL_START_BIT] && link.wdata[CTRL_ENABLE_BIT] &&
                       (state_ff == ST_IDLE)) || sleep_start ||
                      (finish && free_run_ff);

   // next state of the whole converter
   always_comb begin
      nxt_state = state_ff;
      nxt_enable = enable_ff;
      nxt_free_run = free_run_ff;
      nxt_done = done_ff;
      nxt_irq_en = irq_en_ff;
      nxt_first = first_ff;
      nxt_halted_q = link.cpu_halted;
      nxt_select = select_ff;
      nxt_cnt = cnt_ff;
      nxt_code = code_ff;
      nxt_ref = ref_ff;
      nxt_chan = chan_ff;
      nxt_diff = diff_ff;
      nxt_rdata = 8'h00;
      // control writes; the done bit clears on a written one or on an irq ack
      if (wr_ctrl) begin
         nxt_enable = link.wdata[CTRL_ENABLE_BIT];
         nxt_free_run = link.wdata[CTRL_FREE_RUN_BIT];
         nxt_irq_en = link.wdata[CTRL_IRQ_EN_BIT];
         if (link.wdata[CTRL_DONE_BIT]) nxt_done = 1'b0;
         if (link.wdata[CTRL_ENABLE_BIT] && !enable_ff) nxt_first = 1'b1;
      end
      if (link.irq_ack) nxt_done = 1'b0;
      if (link.wr && (link.addr == OFS_SELECT)) nxt_select = link.wdata;
      // selection tracks the register while idle, locked while converting
      if (state_ff == ST_IDLE) begin
         nxt_ref = select_ff[SEL_REF_LSB +: 2];
         nxt_chan = select_ff[4:0];
         nxt_diff = sel_is_diff;
      end
      // conversion sequencing
      if (state_ff == ST_CONVERT) begin
         if (!nxt_enable) begin
            nxt_state = ST_IDLE;
            nxt_cnt = 8'h00;
         end else if (finish) begin
            nxt_code = clamp_code(analog_value_i, diff_ff);
            // completion sets the flag and wins over any clear this cycle
            nxt_done = 1'b1;
            nxt_state = ST_IDLE;
            nxt_cnt = 8'h00;
         end else begin
            nxt_cnt = cnt_ff - 8'h01;
         end
      end
      if (start_now) begin
         nxt_state = ST_CONVERT;
         nxt_cnt = (first_ff || nxt_first) ? FIRST_SYS_CYCLES : NORMAL_SYS_CYCLES;
         nxt_first = 1'b0;
         // a restart samples the freshly unlocked selection
         nxt_ref = select_ff[SEL_REF_LSB +: 2];
         nxt_chan = select_ff[4:0];
         nxt_diff = sel_is_diff;
      end
      if (!nxt_enable) nxt_first = 1'b0;
      // read data stands only in the cycle after the read strobe
      if (link.rd) begin
         unique case (link.addr)
            OFS_CTRL: nxt_rdata = {enable_ff, (state_ff == ST_CONVERT), free_run_ff,
                                   done_ff, irq_en_ff, 3'h0};
            OFS_SELECT: nxt_rdata = select_ff;
            OFS_RES_LOW: nxt_rdata = fmt_low;
            OFS_RES_HIGH: nxt_rdata = fmt_high;
         endcase
      end
   end

   // register stage
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         state_ff <= ST_IDLE;
         enable_ff <= CTRL_RESET[CTRL_ENABLE_BIT];
         free_run_ff <= CTRL_RESET[CTRL_FREE_RUN_BIT];
         done_ff <= CTRL_RESET[CTRL_DONE_BIT];
         irq_en_ff <= CTRL_RESET[CTRL_IRQ_EN_BIT];
         first_ff <= 1'b0;
         halted_q_ff <= 1'b0;
         select_ff <= SELECT_RESET;
         cnt_ff <= 8'h00;
         code_ff <= CODE_RESET;
         ref_ff <= REF_EXTERNAL_PIN;
         chan_ff <= 5'h00;
         diff_ff <= 1'b0;
         rdata_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         enable_ff <= nxt_enable;
         free_run_ff <= nxt_free_run;
         done_ff <= nxt_done;
         irq_en_ff <= nxt_irq_en;
         first_ff <= nxt_first;
         halted_q_ff <= nxt_halted_q;
         select_ff <= nxt_select;
         cnt_ff <= nxt_cnt;
         code_ff <= nxt_code;
         ref_ff <= nxt_ref;
         chan_ff <= nxt_chan;
         diff_ff <= nxt_diff;
         rdata_ff <= nxt_rdata;
      end
   end

   // outputs; the request stays up whether or not the cpu was already awake
   assign link.done_irq = done_ff && irq_en_ff;
   assign link.rdata = rdata_ff;
   assign ref_select_o = ref_ff;
   assign channel_o = chan_ff;
   assign differential_o = diff_ff;
   assign converting_o = (state_ff == ST_CONVERT);
   // sample strobe marks the cycle whose analog value becomes the code, unless a control write clears the enable bit in that cycle
   assign sample_o = finish;
endmodule : convert_ctrl
`default_nettype wire

// ==== src/conv_pkg.sv ====
// shared constants and types for the converter control and the cpu sleep side
`default_nettype none
package conv_pkg;
   // converter register offsets on the link
   localparam logic [1:0] OFS_CTRL = 2'h0;
   localparam logic [1:0] OFS_SELECT = 2'h1;
   localparam logic [1:0] OFS_RES_LOW = 2'h2;
   localparam logic [1:0] OFS_RES_HIGH = 2'h3;
   // control register fields
   localparam int CTRL_ENABLE_BIT = 7;
   localparam int CTRL_START_BIT = 6;
   localparam int CTRL_FREE_RUN_BIT = 5;
   localparam int CTRL_DONE_BIT = 4;
   localparam int CTRL_IRQ_EN_BIT = 3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // select register fields
   localparam int SEL_REF_LSB = 6;
   localparam int SEL_ALIGN_BIT = 5;
   localparam logic [7:0] SELECT_RESET = 8'h00;
   // reference source codes
   localparam logic [1:0] REF_EXTERNAL_PIN = 2'h0;
   localparam logic [1:0] REF_ANALOG_SUPPLY = 2'h1;
   localparam logic [1:0] REF_RESERVED = 2'h2;
   localparam logic [1:0] REF_BANDGAP_2V56 = 2'h3;
   // differential channel codes
   localparam logic [4:0] MUX_DIFF_FIRST = 5'h08;
   localparam logic [4:0] MUX_DIFF_LAST = 5'h1d;
   // code limits on the 12-bit signed analog sample
   localparam logic signed [11:0] SE_CODE_MIN = 12'sh000;
   localparam logic signed [11:0] SE_CODE_MAX = 12'sh3ff;
   localparam logic signed [11:0] DIFF_CODE_MIN = 12'she00;
   localparam logic signed [11:0] DIFF_CODE_MAX = 12'sh1ff;
   localparam logic [9:0] CODE_RESET = 10'h000;
   // conversion timing in converter clocks, then in system clocks
   localparam int CONV_CLK_DIV = 2;
   localparam int FIRST_CONV_CYCLES = 25;
   localparam int NORMAL_CONV_CYCLES = 13;
   localparam logic [7:0] FIRST_SYS_CYCLES = 8'(FIRST_CONV_CYCLES * CONV_CLK_DIV);
   localparam logic [7:0] NORMAL_SYS_CYCLES = 8'(NORMAL_CONV_CYCLES * CONV_CLK_DIV);
   // cpu side register offsets
   localparam logic [2:0] HOST_OFS_CTRL = 3'h4;
   localparam logic [2:0] HOST_OFS_SLEEP = 3'h5;
   localparam logic [2:0] HOST_OFS_STATUS = 3'h6;
   localparam int HOST_GIE_BIT = 0;
   // sleep modes and interrupt vectors
   typedef enum logic [2:0] {
      SLEEP_IDLE, SLEEP_NOISE_REDUCE, SLEEP_POWER_DOWN,
      SLEEP_POWER_SAVE, SLEEP_STANDBY, SLEEP_EXT_STANDBY
   } sleep_mode_e;
   typedef enum logic [1:0] {VEC_NONE, VEC_CONV_DONE, VEC_OTHER} vector_e;
endpackage : conv_pkg
`default_nettype wire

// ==== src/conv_link_if.sv ====
// link between the converter control and the cpu sleep and interrupt side
`default_nettype none
interface conv_link_if;
   import conv_pkg::*;
   logic wr;
   logic rd;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   sleep_mode_e sleep_mode;
   logic cpu_halted;
   logic done_irq;
   logic irq_ack;
   modport dev_mp (
      input wr, rd, addr, wdata, sleep_mode, cpu_halted, irq_ack,
      output rdata, done_irq
   );
   modport cpu_mp (
      output wr, rd, addr, wdata, sleep_mode, cpu_halted, irq_ack,
      input rdata, done_irq
   );
endinterface : conv_link_if
`default_nettype wire

// ==== src/result_format.sv ====
// aligns the 10-bit result into the low and high result bytes
`default_nettype none
module result_format (
   // code and alignment
   input wire logic [9:0] code_i,
   input wire logic left_align_i,
   // result bytes
   output logic [7:0] low_o,
   output logic [7:0] high_o
);
   // purely combinational, so an alignment change shows at once
   always_comb begin
      if (left_align_i) begin
         low_o = {code_i[1:0], 6'h00};
         high_o = code_i[9:2];
      end else begin
         low_o = code_i[7:0];
         high_o = {6'h00, code_i[9:8]};
      end
   end
endmodule : result_format
`default_nettype wire

// ==== src/cpu_sleep_ctrl.sv ====
// cpu side: sleep entry, wake-up, interrupt service and register access
`default_nettype none
module cpu_sleep_ctrl
   import conv_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // link to the converter
   conv_link_if.cpu_mp link,
   // software command port
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // other interrupt source
   input wire logic other_irq_i,
   output logic other_irq_ack_o,
   // service and sleep status
   output logic isr_start_o,
   output logic [1:0] isr_vector_o,
   output logic asleep_o
);
   typedef enum logic {ST_ACTIVE, ST_ASLEEP} cpu_state_e;

   cpu_state_e state_ff, nxt_state;
   sleep_mode_e mode_ff, nxt_mode;
   logic gie_ff, nxt_gie;
   logic ack_ff, nxt_ack;
   logic other_ack_ff, nxt_other_ack;
   logic isr_ff, nxt_isr;
   vector_e vector_ff, nxt_vector;
   logic [1:0] last_ref_ff, nxt_last_ref;
   logic ref_changed_ff, nxt_ref_changed;
   logic suspect_ff, nxt_suspect;
   logic dev_sel_ff, nxt_dev_sel;
   logic [7:0] rdata_ff, nxt_rdata;
   logic lockout;

   // converter accesses pass straight through on the low half of the map
   assign link.wr = wr_i && !addr_i[2];
   assign link.rd = rd_i && !addr_i[2];
   assign link.addr = addr_i[1:0];
   assign link.wdata = wdata_i;
   assign link.sleep_mode = mode_ff;
   assign link.cpu_halted = (state_ff == ST_ASLEEP);
   // one idle cycle after an ack lets the source drop its request
   assign lockout = ack_ff || other_ack_ff;

   // next state of sleep, service and register logic
   always_comb begin
      nxt_state = state_ff;
      nxt_mode = mode_ff;
      nxt_gie = gie_ff;
      nxt_ack = 1'b0;
      nxt_other_ack = 1'b0;
      nxt_isr = 1'b0;
      nxt_vector = vector_ff;
      nxt_last_ref = last_ref_ff;
      nxt_ref_changed = ref_changed_ff;
      nxt_suspect = suspect_ff;
      nxt_dev_sel = rd_i && !addr_i[2];
      nxt_rdata = 8'h00;
      if (wr_i && (addr_i == HOST_OFS_CTRL)) nxt_gie = wdata_i[HOST_GIE_BIT];
      // software prepares the converter first and parks it before deep sleep
      if (wr_i && (addr_i == HOST_OFS_SLEEP) && (state_ff == ST_ACTIVE)) begin
         nxt_state = ST_ASLEEP;
         nxt_mode = sleep_mode_e'(wdata_i[2:0]);
      end
      // any pending request wakes; no return to sleep without a new command
      if ((state_ff == ST_ASLEEP) && (link.done_irq || other_irq_i)) begin
         nxt_state = ST_ACTIVE;
      end
      // the other source is serviced ahead of the converter
      if ((state_ff == ST_ACTIVE) && gie_ff && !lockout) begin
         if (other_irq_i) begin
            nxt_other_ack = 1'b1;
            nxt_isr = 1'b1;
            nxt_vector = VEC_OTHER;
         end else if (link.done_irq) begin
            nxt_ack = 1'b1;
            nxt_isr = 1'b1;
            nxt_vector = VEC_CONV_DONE;
            nxt_suspect = ref_changed_ff;
            nxt_ref_changed = 1'b0;
         end
      end
      // remember a reference change; placed after the ack so the set wins
      if (link.wr && (addr_i[1:0] == OFS_SELECT)) begin
         nxt_last_ref = wdata_i[SEL_REF_LSB +: 2];
         if (wdata_i[SEL_REF_LSB +: 2] != last_ref_ff) nxt_ref_changed = 1'b1;
      end
      if (rd_i && (addr_i == HOST_OFS_STATUS)) begin
         nxt_rdata = {(state_ff == ST_ASLEEP), gie_ff, vector_ff, suspect_ff, mode_ff};
      end else if (rd_i && (addr_i == HOST_OFS_CTRL)) begin
         nxt_rdata = {7'h00, gie_ff};
      end
   end

   // register stage
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         state_ff <= ST_ACTIVE;
         mode_ff <= SLEEP_IDLE;
         gie_ff <= 1'b0;
         ack_ff <= 1'b0;
         other_ack_ff <= 1'b0;
         isr_ff <= 1'b0;
         vector_ff <= VEC_NONE;
         last_ref_ff <= REF_EXTERNAL_PIN;
         ref_changed_ff <= 1'b0;
         suspect_ff <= 1'b0;
         dev_sel_ff <= 1'b0;
         rdata_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         mode_ff <= nxt_mode;
         gie_ff <= nxt_gie;
         ack_ff <= nxt_ack;
         other_ack_ff <= nxt_other_ack;
         isr_ff <= nxt_isr;
         vector_ff <= nxt_vector;
         last_ref_ff <= nxt_last_ref;
         ref_changed_ff <= nxt_ref_changed;
         suspect_ff <= nxt_suspect;
         dev_sel_ff <= nxt_dev_sel;
         rdata_ff <= nxt_rdata;
      end
   end

   // outputs, all from flops
   assign link.irq_ack = ack_ff;
   assign other_irq_ack_o = other_ack_ff;
   assign isr_start_o = isr_ff;
   assign isr_vector_o = vector_ff;
   assign asleep_o = (state_ff == ST_ASLEEP);
   assign rdata_o = dev_sel_ff ? link.rdata : rdata_ff;
endmodule : cpu_sleep_ctrl
`default_nettype wire

// ==== verification/conv_link_properties.sv ====
// timing checks on the link between converter control and cpu side
`default_nettype none
module conv_link_properties
   import conv_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // link signals
   input wire logic wr,
   input wire logic rd,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic [2:0] sleep_mode,
   input wire logic cpu_halted,
   input wire logic done_irq,
   input wire logic irq_ack
);
   // a started conversion ends within the longest first conversion plus slack
   localparam int DONE_SPAN = 52;
   localparam logic [7:0] FIRST_DONE = 8'(FIRST_SYS_CYCLES + 8'h01);
   logic en_ff, ie_ff, first_on_ff;
   logic nxt_en, nxt_ie, nxt_first_on;
   logic [7:0] cnt_ff, nxt_cnt;
   logic ctrl_wr, first_go, stop_go, ack_or_wr;
   // mirror of enable and irq enable, seen only through link writes
   assign ctrl_wr = wr && (addr == OFS_CTRL);
   assign first_go = ctrl_wr && (wdata[7:6] == 2'b11) && (wdata[4:3] == 2'b11) && !en_ff;
   assign stop_go = ctrl_wr && !(wdata[CTRL_ENABLE_BIT] && wdata[CTRL_IRQ_EN_BIT]);
   assign ack_or_wr = irq_ack || ctrl_wr;
   // next values; the counter restarts at 1 on a first start and counts on freely past completion
   always_comb begin
      nxt_en = en_ff;
      nxt_ie = ie_ff;
      if (ctrl_wr) begin
         nxt_en = wdata[CTRL_ENABLE_BIT];
         nxt_ie = wdata[CTRL_IRQ_EN_BIT];
      end
      nxt_first_on = first_go || (first_on_ff && !done_irq && !stop_go);
      nxt_cnt = first_go ? 8'h01 : 8'(cnt_ff + 8'h01);
   end
   // helper registers
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         en_ff <= 1'b0;
         ie_ff <= 1'b0;
         first_on_ff <= 1'b0;
         cnt_ff <= 8'h00;
      end else begin
         en_ff <= nxt_en;
         ie_ff <= nxt_ie;
         first_on_ff <= nxt_first_on;
         cnt_ff <= nxt_cnt;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   sequence s_manual_start;
      ctrl_wr && wdata[CTRL_ENABLE_BIT] && wdata[CTRL_START_BIT] && wdata[CTRL_IRQ_EN_BIT];
   endsequence
   sequence s_sleep_start;
      $rose(cpu_halted) && (sleep_mode inside {SLEEP_IDLE, SLEEP_NOISE_REDUCE}) && en_ff && ie_ff;
   endsequence
   sequence s_finish;
      ##[1:DONE_SPAN] (done_irq || stop_go);
   endsequence
   a_start_completes: assert property (s_manual_start |-> s_finish)
      else $error("started conversion never completed");
   a_sleep_starts: assert property (s_sleep_start |-> s_finish)
      else $error("halt in idle or noise sleep did not convert");
   a_first_length: assert property (first_on_ff && done_irq |-> cnt_ff == FIRST_DONE)
      else $error("first conversion length wrong");
   a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside read slot");
   a_wake_on_done: assert property (done_irq && cpu_halted |=> !cpu_halted)
      else $error("completion did not wake cpu");
   a_ack_clears: assert property (irq_ack |-> $past(done_irq) ##1 !done_irq)
      else $error("vector did not clear done flag");
   a_ack_single: assert property (irq_ack |=> !irq_ack)
      else $error("ack longer than one cycle");
   a_flag_drop_cause: assert property ($fell(done_irq) |-> $past(ack_or_wr))
      else $error("done request dropped without cause");
endmodule : conv_link_properties
`default_nettype wire

// ==== verification/tb_adc_result_and_sleep_canceler.sv ====
// bench joining converter control and cpu sleep side over the link
`default_nettype none
module tb_adc_result_and_sleep_canceler import conv_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic srst_i = 1'b1;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic other_irq_i = 1'b0;
   logic signed [11:0] analog_value_i = 12'sh000;
   logic [7:0] rdata_o;
   logic other_irq_ack_o, isr_start_o, asleep_o, converting_o, sample_o, differential_o;
   logic [1:0] isr_vector_o, ref_select_o;
   logic [4:0] channel_o;
   int n_fail = 0;
   int num_checks = 0;
   conv_link_if link ();
   convert_ctrl u_convert_ctrl (.clock_i, .srst_i, .link(link), .ref_select_o, .channel_o,
      .differential_o, .converting_o, .sample_o, .analog_value_i);
   cpu_sleep_ctrl u_cpu_sleep_ctrl (.clock_i, .srst_i, .link(link), .addr_i, .wdata_i, .wr_i,
      .rd_i, .rdata_o, .other_irq_i, .other_irq_ack_o, .isr_start_o, .isr_vector_o, .asleep_o);
   conv_link_properties u_props (.clock_i, .srst_i, .wr(link.wr), .rd(link.rd),
      .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .sleep_mode(link.sleep_mode),
      .cpu_halted(link.cpu_halted), .done_irq(link.done_irq), .irq_ack(link.irq_ack));
   // 250 MHz clock
   always #2 clock_i = ~clock_i;
   // other source holds its request until acknowledged
   always @(posedge clock_i) if (other_irq_ack_o) other_irq_i <= 1'b0;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      check(rdata_o, exp);
   endtask : rd_chk
   task automatic rd_pair(input logic [7:0] lo, input logic [7:0] hi);
      rd_chk({1'b0, OFS_RES_LOW}, lo);
      rd_chk({1'b0, OFS_RES_HIGH}, hi);
   endtask : rd_pair
   // counts busy cycles; bounded so a stuck busy cannot hang the run
   task automatic conv(input logic [7:0] sel, input logic [11:0] v, input logic [7:0] len);
      int n;
      int s;
      n = 0;
      s = 0;
      @(posedge clock_i);
      analog_value_i <= v;
      wr_reg({1'b0, OFS_SELECT}, sel);
      wr_reg({1'b0, OFS_CTRL}, 8'hd8);
      #1;
      while (converting_o === 1'b1 && n < 200) begin
         n++;
         if (sample_o === 1'b1) s++;
         @(posedge clock_i);
         #1;
      end
      check(8'(n), len);
      check(8'(s), 8'h01);
   endtask : conv
   task automatic wait_isr(input logic [1:0] vec);
      int i;
      i = 0;
      @(posedge clock_i);
      #1;
      while (isr_start_o !== 1'b1 && i < 150) begin
         @(posedge clock_i);
         #1;
         i++;
      end
      check(8'(isr_start_o), 8'h01);
      check(8'(isr_vector_o), 8'(vec));
   endtask : wait_isr
   task automatic t_single();
      for (int a = 0; a < 4; a++) rd_chk(3'(a), 8'h00);
      conv(8'h40, 12'h500, FIRST_SYS_CYCLES);
      rd_pair(8'hff, 8'h03);
      check(8'(ref_select_o), 8'(REF_ANALOG_SUPPLY));
      wr_reg({1'b0, OFS_SELECT}, 8'h60);
      rd_pair(8'hc0, 8'hff);
      conv(8'h41, 12'h2a5, NORMAL_SYS_CYCLES);
      rd_pair(8'ha5, 8'h02);
      conv(8'h40, 12'hffb, NORMAL_SYS_CYCLES);
      rd_pair(8'h00, 8'h00);
      rd_chk({1'b0, OFS_CTRL}, 8'h98);
      wr_reg({1'b0, OFS_CTRL}, 8'h98);
      rd_chk({1'b0, OFS_CTRL}, 8'h88);
   endtask : t_single
   task automatic t_diff();
      conv(8'he8, 12'he70, NORMAL_SYS_CYCLES);
      rd_pair(8'h00, 8'h9c);
      check(8'(differential_o), 8'h01);
      check(8'(channel_o), 8'h08);
      check(8'(ref_select_o), 8'(REF_BANDGAP_2V56));
      conv(8'hc8, 12'hd44, NORMAL_SYS_CYCLES);
      rd_pair(8'h00, 8'h02);
      conv(8'hc8, 12'h258, NORMAL_SYS_CYCLES);
      rd_pair(8'hff, 8'h01);
   endtask : t_diff
   task automatic t_abort();
      // a new input value shows whether an aborted run still wrote a result
      @(posedge clock_i);
      analog_value_i <= 12'h000;
      wr_reg({1'b0, OFS_CTRL}, 8'hd8);
      repeat (5) @(posedge clock_i);
      wr_reg({1'b0, OFS_CTRL}, 8'h00);
      #1;
      check(8'(converting_o), 8'h00);
      repeat (40) @(posedge clock_i);
      rd_chk({1'b0, OFS_CTRL}, 8'h00);
      rd_pair(8'hff, 8'h01);
   endtask : t_abort
   task automatic t_sleep();
      wr_reg(HOST_OFS_CTRL, 8'h01);
      wr_reg({1'b0, OFS_CTRL}, 8'h88);
      wr_reg(HOST_OFS_SLEEP, {5'h00, SLEEP_NOISE_REDUCE});
      wait_isr(VEC_CONV_DONE);
      check(8'(asleep_o), 8'h00);
      repeat (20) @(posedge clock_i);
      #1;
      check(8'(asleep_o), 8'h00);
      rd_chk({1'b0, OFS_CTRL}, 8'h88);
      rd_chk(HOST_OFS_STATUS, 8'h59);
   endtask : t_sleep
   // another source wakes first; completion still requests service
   task automatic t_other();
      wr_reg(HOST_OFS_SLEEP, {5'h00, SLEEP_IDLE});
      repeat (3) @(posedge clock_i);
      other_irq_i <= 1'b1;
      wait_isr(VEC_OTHER);
      check(8'(other_irq_ack_o), 8'h01);
      wait_isr(VEC_CONV_DONE);
      rd_chk(HOST_OFS_STATUS, 8'h50);
   endtask : t_other
   task automatic t_deep();
      wr_reg(HOST_OFS_SLEEP, {5'h00, SLEEP_POWER_DOWN});
      repeat (10) @(posedge clock_i);
      other_irq_i <= 1'b1;
      #1;
      check(8'(asleep_o), 8'h01);
      check(8'(converting_o), 8'h00);
      wait_isr(VEC_OTHER);
      rd_chk({1'b0, OFS_CTRL}, 8'h88);
      // off and on again so the differential result gets the long conversion
      wr_reg({1'b0, OFS_CTRL}, 8'h08);
      conv(8'hc8, 12'h258, FIRST_SYS_CYCLES);
      rd_pair(8'hff, 8'h01);
   endtask : t_deep
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   // main sequence
   initial begin
      repeat (8) @(posedge clock_i);
      srst_i <= 1'b0;
      t_single();
      t_diff();
      t_abort();
      t_sleep();
      t_other();
      t_deep();
      wrap_up();
   end
   // watchdog, far beyond the several hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clock_i);
      n_fail++;
      wrap_up();
   end
endmodule : tb_adc_result_and_sleep_canceler
`default_nettype wire
